// [rtl/reset_source_pkg.sv]
// Constants and types shared by the reset source controller
package reset_source_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on the Avalon-MM slave)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_BROWNOUT_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_RESET_CAUSE_FLAGS = 4'h4;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BC_SW_ENABLE_BIT = 7;
    localparam int BC_FAST_START_BIT = 6;
    localparam int BC_READY_BIT = 0;
    localparam int RF_STACK_OVER_BIT = 7;
    localparam int RF_STACK_UNDER_BIT = 6;
    localparam int RF_WATCHDOG_BIT = 4;
    localparam int RF_PIN_BIT = 3;
    localparam int RF_RESET_INSTR_BIT = 2;
    localparam int RF_POWER_ON_BIT = 1;
    localparam int RF_BROWNOUT_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_SW_ENABLE = 1'b1;
    localparam logic RST_FAST_START = 1'b0;
    localparam logic [7:0] RST_FLAGS_POWER_ON = 8'h1c;
    localparam logic [7:0] FLAGS_IMPL_MASK = 8'hdf;
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    // ------------------------------------------------------------
    // Brown-out mode configuration codes
    // ------------------------------------------------------------
    localparam logic [1:0] BOR_MODE_ALWAYS_ON = 2'h3;
    localparam logic [1:0] BOR_MODE_SLEEP_OFF = 2'h2;
    localparam logic [1:0] BOR_MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] BOR_MODE_OFF = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned POWERUP_TIME_MS = 64;
    localparam int unsigned TIMER_CYCLES_DEF = POWERUP_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned SETTLE_CYCLES = 10;
    localparam int unsigned FILTER_TIME_NS = 300;
    localparam int unsigned FILTER_CYCLES =
        (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEQ_CNT_W = 20;
    localparam int FILT_CNT_W = 4;

    // ------------------------------------------------------------
    // Start-up sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_POWER = 5'b00001,
        ST_TIMER = 5'b00010,
        ST_PIN = 5'b00100,
        ST_SETTLE = 5'b01000,
        ST_RUN = 5'b10000
    } seq_state_e;
endpackage

// [rtl/pin_noise_filter.sv]
// Glitch filter for the external reset pin
`timescale 1ns/10ps
module pin_noise_filter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_sync_b,
    // Pin
    input wire logic pin_raw,
    output logic pin_clean
);
    import reset_source_pkg::*;

    logic [FILT_CNT_W-1:0] cnt_reg;
    logic [FILT_CNT_W-1:0] cnt_next;
    logic clean_next;

    // A new level is accepted only once it has held for the whole window
    wire differs = pin_raw != pin_clean;
    wire expired = cnt_reg == FILT_CNT_W'(FILTER_CYCLES - 1);

    assign cnt_next = (!differs || expired) ? '0 : cnt_reg + 1'b1;
    assign clean_next = (differs && expired) ? pin_raw : pin_clean;

    // Idles high, matching the weak pull-up
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cnt_reg <= '0;
            pin_clean <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            pin_clean <= clean_next;
        end
    end
endmodule

// [rtl/reset_source_control.sv]
// Reset source control, reset-cause flags and start-up sequencing
`timescale 1ns/10ps
module reset_source_control #(
    parameter int unsigned TIMER_CYCLES = reset_source_pkg::TIMER_CYCLES_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Configuration word
    input wire logic [1:0] brownout_mode_cfg,
    input wire logic low_power_brownout,
    input wire logic master_clear_pin_enable,
    input wire logic low_voltage_program_cfg,
    input wire logic powerup_timer_disable_n,
    input wire logic stack_reset_enable,
    input wire logic prog_mode,
    // Analog detectors
    input wire logic vdd_below_bor,
    input wire logic bor_circuit_ready,
    input wire logic vdd_below_lowpwr,
    // External reset pin
    input wire logic master_clear_pin,
    input wire logic gp_pullup_sw,
    output logic pin_pullup_en,
    output logic gp_pin_value,
    // CPU events
    input wire logic cpu_sleeping,
    input wire logic sleep_instr,
    input wire logic watchdog_clear_instr,
    input wire logic watchdog_timeout,
    input wire logic reset_instr,
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire logic wake_irq,
    input wire logic global_irq_enable,
    // Reset and wake outputs
    output logic device_reset,
    output logic pc_load_zero,
    output logic wake_resume,
    output logic irq_vector_req,
    output logic [15:0] irq_vector_addr,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    // Analog controls
    output logic bor_enable,
    output logic bandgap_force_on
);
    import reset_source_pkg::*;

    // ------------------------------------------------------------
    // Reset release synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_reg;
    wire rst_sync_b = rst_pipe_reg[1];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_reg <= 2'b00;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    seq_state_e state_reg;
    seq_state_e state_next;
    logic [SEQ_CNT_W-1:0] cnt_reg;
    logic [SEQ_CNT_W-1:0] cnt_next;
    logic sw_en_reg;
    logic fast_start_reg;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic pin_clean;

    // ------------------------------------------------------------
    // Pin filter
    // ------------------------------------------------------------
    pin_noise_filter u_pin_filter (
        .ref_clk(ref_clk),
        .rst_sync_b(rst_sync_b),
        .pin_raw(master_clear_pin),
        .pin_clean(pin_clean)
    );

    // ------------------------------------------------------------
    // Detector and pin decode
    // ------------------------------------------------------------
    wire mode_on = brownout_mode_cfg == BOR_MODE_ALWAYS_ON;
    wire mode_sleep_off = brownout_mode_cfg == BOR_MODE_SLEEP_OFF;
    wire mode_sw = brownout_mode_cfg == BOR_MODE_SOFTWARE;
    wire bor_on = mode_on | (mode_sleep_off & !cpu_sleeping)
        | (mode_sw & sw_en_reg);
    wire fast_start_on = fast_start_reg & (mode_sleep_off | mode_sw);
    wire bor_ready = bor_on & bor_circuit_ready;
    wire bor_trip = bor_ready & vdd_below_bor;
    wire lp_trip = low_power_brownout & vdd_below_lowpwr;
    wire pwr_trip = bor_trip | lp_trip;
    wire pin_en = low_voltage_program_cfg | master_clear_pin_enable;
    wire pin_low = pin_en & !pin_clean;
    wire powerup_timer_en = !powerup_timer_disable_n;

    // ------------------------------------------------------------
    // Reset and wake events, only while running; power_evt is not gated
    // ------------------------------------------------------------
    wire running = state_reg == ST_RUN;
    wire awake = running & !cpu_sleeping;
    wire asleep = running & cpu_sleeping;
    wire pin_evt = running & pin_low;
    wire wdt_rst = awake & watchdog_timeout;
    wire wdt_wake = asleep & watchdog_timeout;
    wire irq_wake = asleep & wake_irq & !watchdog_timeout;
    wire rinstr_evt = awake & reset_instr;
    wire ovf_evt = awake & stack_overflow;
    wire unf_evt = awake & stack_underflow;
    wire stk_rst = (ovf_evt | unf_evt) & stack_reset_enable;
    wire soft_rst = pin_evt | wdt_rst | rinstr_evt | stk_rst;
    wire power_evt = prog_mode | pwr_trip;

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait state, then complete
    // ------------------------------------------------------------
    logic wait_reg;
    logic [31:0] rdata_reg;
    wire access = read | write;
    wire done = access & !wait_reg;
    wire sel_bc = address == ADDR_BROWNOUT_CONTROL;
    wire sel_fl = address == ADDR_RESET_CAUSE_FLAGS;
    wire wr_bc = done & write & byteenable[0] & sel_bc;
    wire wr_fl = done & write & byteenable[0] & sel_fl;
    wire [7:0] bc_word = {sw_en_reg, fast_start_reg, 5'h00, bor_ready};
    wire [31:0] rd_word = sel_bc ? {24'h000000, bc_word}
        : sel_fl ? {24'h000000, flags_reg & FLAGS_IMPL_MASK} : 32'h00000000;
    wire wait_next = access ? !wait_reg : 1'b1;

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            wait_reg <= wait_next;
            if (read && wait_reg) begin
                rdata_reg <= rd_word;
            end
        end
    end

    assign waitrequest = wait_reg;
    assign readdata = rdata_reg;

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    // Power events restart the whole sequence; other resets skip the
    // timer and only wait for the pin and the settle delay.
    always_comb begin
        state_next = state_reg;
        if (power_evt) begin
            state_next = ST_POWER;
        end else if (soft_rst) begin
            state_next = ST_PIN;
        end else begin
            case (state_reg)
                ST_POWER: begin
                    state_next = powerup_timer_en ? ST_TIMER : ST_PIN;
                end
                ST_TIMER: begin
                    // Counts regardless of the pin level
                    if (cnt_reg == SEQ_CNT_W'(TIMER_CYCLES - 1)) begin
                        state_next = ST_PIN;
                    end
                end
                ST_PIN: begin
                    if (!pin_low) begin
                        state_next = ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (pin_low) begin
                        state_next = ST_PIN;
                    end else if (cnt_reg == SEQ_CNT_W'(SETTLE_CYCLES - 1)) begin
                        state_next = ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_next = ST_RUN;
                end
                default: begin
                    state_next = ST_POWER;
                end
            endcase
        end
    end

    assign cnt_next = (state_next != state_reg || power_evt) ? '0 : cnt_reg + 1'b1;

    // ------------------------------------------------------------
    // Reset-cause flags: hardware events override a software write
    // ------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        if (wr_fl) begin
            flags_next = writedata[7:0] & FLAGS_IMPL_MASK;
        end
        if (prog_mode) begin
            flags_next = RST_FLAGS_POWER_ON;
        end else if (pwr_trip) begin
            flags_next[RF_STACK_OVER_BIT] = 1'b0;
            flags_next[RF_STACK_UNDER_BIT] = 1'b0;
            flags_next[RF_WATCHDOG_BIT] = 1'b1;
            flags_next[RF_PIN_BIT] = 1'b1;
            flags_next[RF_BROWNOUT_BIT] = 1'b0;
        end else begin
            if (pin_evt) begin
                flags_next[RF_PIN_BIT] = 1'b0;
            end
            if (wdt_rst) begin
                flags_next[RF_WATCHDOG_BIT] = 1'b0;
            end
            if (rinstr_evt) begin
                flags_next[RF_RESET_INSTR_BIT] = 1'b0;
            end
            if (ovf_evt) begin
                flags_next[RF_STACK_OVER_BIT] = 1'b1;
            end
            if (unf_evt) begin
                flags_next[RF_STACK_UNDER_BIT] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Sleep status flags
    // ------------------------------------------------------------
    logic to_next;
    logic powerdown_next;

    always_comb begin
        to_next = timeout_flag_n;
        powerdown_next = powerdown_flag_n;
        if (power_evt || watchdog_clear_instr) begin
            to_next = 1'b1;
            powerdown_next = 1'b1;
        end else if (wdt_rst) begin
            to_next = 1'b0;
        end else if (wdt_wake) begin
            to_next = 1'b0;
            powerdown_next = 1'b0;
        end else if (irq_wake || (pin_evt && cpu_sleeping) || sleep_instr) begin
            to_next = 1'b1;
            powerdown_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State, registers and outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_reg <= ST_POWER;
            cnt_reg <= '0;
            flags_reg <= RST_FLAGS_POWER_ON;
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            flags_reg <= flags_next;
            timeout_flag_n <= to_next;
            powerdown_flag_n <= powerdown_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sw_en_reg <= RST_SW_ENABLE;
            fast_start_reg <= RST_FAST_START;
        end else if (power_evt) begin
            sw_en_reg <= RST_SW_ENABLE;
            fast_start_reg <= RST_FAST_START;
        end else if (wr_bc) begin
            sw_en_reg <= writedata[BC_SW_ENABLE_BIT];
            fast_start_reg <= writedata[BC_FAST_START_BIT];
        end
    end

    // The pin is an input only; nothing here can pull it low
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            device_reset <= 1'b1;
            pc_load_zero <= 1'b0;
            wake_resume <= 1'b0;
            irq_vector_req <= 1'b0;
            pin_pullup_en <= 1'b1;
            gp_pin_value <= 1'b0;
            bor_enable <= 1'b0;
            bandgap_force_on <= 1'b0;
        end else begin
            device_reset <= state_next != ST_RUN;
            pc_load_zero <= !running && state_next == ST_RUN;
            wake_resume <= wdt_wake | irq_wake;
            irq_vector_req <= irq_wake & global_irq_enable;
            pin_pullup_en <= pin_en | gp_pullup_sw;
            gp_pin_value <= pin_en ? 1'b0 : pin_clean;
            bor_enable <= bor_on;
            bandgap_force_on <= fast_start_on;
        end
    end

    assign irq_vector_addr = IRQ_VECTOR;
endmodule

// [tb/reset_source_control_properties.sv]
// Port-level assertions for the reset source controller
`timescale 1ns/10ps
module reset_source_control_properties #(
    parameter int unsigned TIMER_CYCLES = 50
) (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // Configuration and detectors
    input wire logic [1:0] brownout_mode_cfg,
    input wire logic low_power_brownout,
    input wire logic master_clear_pin_enable,
    input wire logic low_voltage_program_cfg,
    input wire logic stack_reset_enable,
    input wire logic vdd_below_lowpwr,
    input wire logic master_clear_pin,
    // CPU events and outputs
    input wire logic cpu_sleeping,
    input wire logic watchdog_timeout,
    input wire logic reset_instr,
    input wire logic stack_overflow,
    input wire logic wake_irq,
    input wire logic global_irq_enable,
    input wire logic pin_pullup_en,
    input wire logic device_reset,
    input wire logic pc_load_zero,
    input wire logic wake_resume,
    input wire logic irq_vector_req,
    input wire logic [15:0] irq_vector_addr,
    input wire logic timeout_flag_n,
    input wire logic bor_enable,
    input wire logic bandgap_force_on
);
    // ------------------------------------------------------------
    // Arm only once the internal reset copy has left its flops
    // ------------------------------------------------------------
    logic [1:0] up_reg;
    logic live;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) up_reg <= 2'h0;
        else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    end
    assign live = (up_reg == 2'h3);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b || !live);
    logic pin_on;
    assign pin_on = master_clear_pin_enable || low_voltage_program_cfg;

    a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    a_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_mode_off_fixed: assert property ((brownout_mode_cfg == 2'h0)[*2] |-> !bor_enable)
        else $error("detector on in off mode");
    a_mode_on_fixed: assert property ((brownout_mode_cfg == 2'h3)[*2] |->
        bor_enable && !bandgap_force_on) else $error("always-on mode wrong");
    a_pin_holds_reset: assert property ((pin_on && !master_clear_pin)[*6] |=> device_reset)
        else $error("low pin did not reset");
    a_pullup_when_pin: assert property (pin_on [*2] |-> pin_pullup_en)
        else $error("pin pull-up missing");
    a_pin_settle_hold: assert property ($rose(master_clear_pin) && device_reset |->
        device_reset [*8]) else $error("run began too soon after pin");
    a_wdt_wake_no_reset: assert property (watchdog_timeout && cpu_sleeping && !device_reset
        |=> wake_resume && !device_reset) else $error("watchdog wake wrong");
    a_irq_wake_vector: assert property (wake_irq && global_irq_enable && cpu_sleeping
        && !watchdog_timeout && !device_reset |=> irq_vector_req && irq_vector_addr == 16'h0004)
        else $error("interrupt wake wrong");
    a_wdt_awake_reset: assert property (watchdog_timeout && !cpu_sleeping && !device_reset
        |=> device_reset && !timeout_flag_n) else $error("watchdog reset wrong");
    a_instr_reset: assert property (reset_instr && !cpu_sleeping && !device_reset
        |=> device_reset) else $error("reset instruction ignored");
    a_stack_reset: assert property (stack_overflow && stack_reset_enable && !cpu_sleeping
        && !device_reset |=> device_reset) else $error("stack reset ignored");
    a_lp_trip_reset: assert property (low_power_brownout && vdd_below_lowpwr
        |=> device_reset) else $error("low-power trip ignored");
    a_run_pulse_once: assert property (pc_load_zero |=> !pc_load_zero && !device_reset)
        else $error("restart pulse wrong");
    c_irq_wake: cover property (irq_vector_req);
    c_wdt_wake: cover property (wake_resume);
    c_restart: cover property (pc_load_zero);
endmodule

bind reset_source_control reset_source_control_properties #(.TIMER_CYCLES(TIMER_CYCLES)) i_props (
    .ref_clk, .rst_b, .read, .write, .waitrequest, .brownout_mode_cfg, .low_power_brownout,
    .master_clear_pin_enable, .low_voltage_program_cfg, .stack_reset_enable, .vdd_below_lowpwr,
    .master_clear_pin, .cpu_sleeping, .watchdog_timeout, .reset_instr, .stack_overflow,
    .wake_irq, .global_irq_enable, .pin_pullup_en, .device_reset, .pc_load_zero, .wake_resume,
    .irq_vector_req, .irq_vector_addr, .timeout_flag_n, .bor_enable, .bandgap_force_on);

// [tb/supply_pin_model.sv]
// Model of the external reset pin and the supply detectors
`timescale 1ns/10ps
module supply_pin_model #(
    parameter int LAG = 3
) (
    // Controls from the bench
    input wire logic ref_clk,
    input wire logic pin_low_req,
    input wire logic bor_dip_req,
    input wire logic lp_dip_req,
    // Device side
    input wire logic bor_enable,
    input wire logic pin_pullup_en,
    output logic master_clear_pin,
    output logic vdd_below_bor,
    output logic bor_circuit_ready,
    output logic vdd_below_lowpwr
);
    logic [3:0] lag_cnt = 4'h0;
    logic float_bit = 1'b0;
    // Detector needs a few cycles to come up, drops at once
    always @(posedge ref_clk) begin
        lag_cnt <= !bor_enable ? 4'h0 : (lag_cnt == LAG[3:0] ? lag_cnt : lag_cnt + 4'h1);
        float_bit <= ~float_bit;
    end
    assign bor_circuit_ready = bor_enable && (lag_cnt == LAG[3:0]);
    // Undriven pin without pull-up floats: toggle so no value is trusted
    assign master_clear_pin = pin_low_req ? 1'b0 : (pin_pullup_en ? 1'b1 : float_bit);
    assign vdd_below_bor = bor_dip_req;
    assign vdd_below_lowpwr = lp_dip_req;
endmodule

// [tb/reset_source_control_test.sv]
// Self-checking bench for the reset source controller
`timescale 1ns/10ps
module reset_source_control_test;
    import reset_source_pkg::*;
    localparam int unsigned PW = 50;
    logic ref_clk, rst_b, read, write, waitrequest, lpb, mcpe, lvcfg, ptd, sre, prog, gpu, ppu;
    logic [3:0] address;
    logic [31:0] writedata, readdata;
    logic [1:0] mode;
    logic mcp, vbb, rdy, vlp, slp, wdt, rsi, sov, sun, wki, ien, gpv, dr, pcz, wr_, ivr, tfn, pfn;
    logic be, bgf, pin_low, lp_dip;
    logic [15:0] iva;
    int err_count, total_checks, n;
    logic [7:0] q;

    reset_source_control #(.TIMER_CYCLES(PW)) i_reset_source_control (
        .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
        .waitrequest(waitrequest), .brownout_mode_cfg(mode), .low_power_brownout(lpb),
        .master_clear_pin_enable(mcpe), .low_voltage_program_cfg(lvcfg),
        .powerup_timer_disable_n(ptd), .stack_reset_enable(sre), .prog_mode(prog),
        .vdd_below_bor(vbb), .bor_circuit_ready(rdy), .vdd_below_lowpwr(vlp),
        .master_clear_pin(mcp), .gp_pullup_sw(gpu), .pin_pullup_en(ppu), .gp_pin_value(gpv),
        .cpu_sleeping(slp), .sleep_instr(1'b0), .watchdog_clear_instr(1'b0),
        .watchdog_timeout(wdt), .reset_instr(rsi), .stack_overflow(sov),
        .stack_underflow(sun), .wake_irq(wki), .global_irq_enable(ien), .device_reset(dr),
        .pc_load_zero(pcz), .wake_resume(wr_), .irq_vector_req(ivr), .irq_vector_addr(iva),
        .timeout_flag_n(tfn), .powerdown_flag_n(pfn), .bor_enable(be), .bandgap_force_on(bgf));
    supply_pin_model i_supply_pin_model (
        .ref_clk(ref_clk), .pin_low_req(pin_low), .bor_dip_req(1'b0), .lp_dip_req(lp_dip),
        .bor_enable(be), .pin_pullup_en(ppu), .master_clear_pin(mcp), .vdd_below_bor(vbb),
        .bor_circuit_ready(rdy), .vdd_below_lowpwr(vlp));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        address <= a;
        writedata <= {24'h0, d};
        read <= !w;
        write <= w;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("register", e, q);
    endtask
    task automatic run_wait();
        n = 0;
        while (dr !== 1'b0) begin
            @(posedge ref_clk);
            n++;
        end
        chk("restart_pulse", 8'h1, {7'h0, pcz});
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        cyc(20000);
        err_count++;
        end_of_test();
    end

    logic [7:0] exp_flags [5] = '{8'h0f, 8'h1b, 8'h9f, 8'h5f, 8'h17};
    logic [1:0] m;
    initial begin
        {rst_b, read, write, lpb, lvcfg, ptd, prog, gpu, slp, wdt, rsi, sov, sun, wki, ien} = '0;
        {mcpe, sre, pin_low} = 3'b111;
        lp_dip = 1'b0;
        mode = BOR_MODE_SOFTWARE;
        address = 4'h0;
        writedata = 32'h0;
        err_count = 0;
        total_checks = 0;
        cyc(16);
        rst_b <= 1'b1;
        // Pin held past the power-up timer, then released
        cyc(150);
        pin_low <= 1'b0;
        run_wait();
        chk("pin_to_run", 8'h1, {7'h0, n >= 10 && n <= 20});
        rd(ADDR_BROWNOUT_CONTROL, 8'h81);
        rd(ADDR_RESET_CAUSE_FLAGS, RST_FLAGS_POWER_ON);
        rd(4'h8, 8'h00);
        bus(1'b1, ADDR_RESET_CAUSE_FLAGS, 8'hff);
        rd(ADDR_RESET_CAUSE_FLAGS, 8'hdf);
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            mode <= m;
            bus(1'b1, ADDR_BROWNOUT_CONTROL, 8'h40);
            cyc(6);
            chk("bor_enable", {7'h0, m[1]}, {7'h0, be});
            chk("bandgap", {7'h0, m[0] ^ m[1]}, {7'h0, bgf});
            rd(ADDR_BROWNOUT_CONTROL, {7'h20, m[1]});
        end
        mode <= BOR_MODE_SOFTWARE;
        bus(1'b1, ADDR_BROWNOUT_CONTROL, 8'h81);
        cyc(6);
        rd(ADDR_BROWNOUT_CONTROL, 8'h81);
        // Each awake reset source in turn, flags rearmed first
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, ADDR_RESET_CAUSE_FLAGS, 8'h1f);
            wdt <= (k == 0);
            rsi <= (k == 1);
            sov <= (k == 2);
            sun <= (k == 3);
            pin_low <= (k == 4);
            cyc(1);
            {wdt, rsi, sov, sun} <= 4'h0;
            cyc(8);
            pin_low <= 1'b0;
            run_wait();
            chk("no_timer", 8'h1, {7'h0, n < PW});
            rd(ADDR_RESET_CAUSE_FLAGS, exp_flags[k]);
            if (k == 0) chk("timeout_n", 8'h0, {7'h0, tfn});
        end
        sre <= 1'b0;
        sov <= 1'b1;
        cyc(1);
        sov <= 1'b0;
        cyc(3);
        chk("stack_no_reset", 8'h0, {7'h0, dr});
        rd(ADDR_RESET_CAUSE_FLAGS, 8'h97);
        // Wake from sleep by interrupt, then by watchdog
        {slp, ien, wki} <= 3'b111;
        cyc(1);
        wki <= 1'b0;
        cyc(1);
        chk("irq_req", 8'h1, {7'h0, ivr});
        chk("irq_vec", 8'h04, iva[7:0]);
        wdt <= 1'b1;
        cyc(1);
        wdt <= 1'b0;
        cyc(1);
        chk("wake", 8'h2, {6'h0, wr_, dr});
        chk("sleep_flags", 8'h0, {6'h0, tfn, pfn});
        slp <= 1'b0;
        // Low-power detector: disabled, then enabled
        lp_dip <= 1'b1;
        cyc(20);
        chk("lp_off", 8'h0, {7'h0, dr});
        bus(1'b1, ADDR_RESET_CAUSE_FLAGS, 8'hdf);
        lpb <= 1'b1;
        cyc(5);
        {lpb, lp_dip} <= 2'b00;
        run_wait();
        chk("timer_run", 8'h1, {7'h0, n >= PW});
        rd(ADDR_RESET_CAUSE_FLAGS, 8'h1e);
        // Pin function off: plain input with software pull-up
        {mcpe, gpu} <= 2'b01;
        pin_low <= 1'b1;
        cyc(20);
        chk("pin_off", 8'h0, {6'h0, dr, gpv});
        pin_low <= 1'b0;
        cyc(8);
        chk("gp_input", 8'h3, {6'h0, gpv, ppu});
        gpu <= 1'b0;
        cyc(3);
        chk("sw_pullup", 8'h0, {7'h0, ppu});
        lvcfg <= 1'b1;
        cyc(3);
        chk("lvp_pullup", 8'h1, {7'h0, ppu});
        {mcpe, lvcfg} <= 2'b10;
        prog <= 1'b1;
        cyc(5);
        prog <= 1'b0;
        run_wait();
        chk("prog_timer", 8'h1, {7'h0, n >= PW});
        rd(ADDR_RESET_CAUSE_FLAGS, RST_FLAGS_POWER_ON);
        {ptd, prog} <= 2'b11;
        cyc(5);
        prog <= 1'b0;
        run_wait();
        chk("timer_off", 8'h1, {7'h0, n < PW});
        end_of_test();
    end
endmodule
